/* common/timer_pkg.sv */
// Constants, register map and carrier types for the cascadable timers
package timer_pkg;
  // Register-file addresses; bank one holds the first and second high bytes and the capture register
  localparam logic [7:0] ADDR_FIRST_LO = 8'h00;
  localparam logic [7:0] ADDR_SECOND_LO = 8'h01;
  localparam logic [7:0] ADDR_THIRD_LO = 8'h02;
  localparam logic [7:0] ADDR_THIRD_HI = 8'h03;
  localparam logic [7:0] ADDR_FIRST_PRESCALE = 8'h04;
  localparam logic [7:0] ADDR_SECOND_PRESCALE = 8'h05;
  localparam logic [7:0] ADDR_PRESCALE_CASCADE = 8'h06;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h07;
  localparam logic [7:0] ADDR_THIRD_MODE = 8'h08;
  localparam logic [7:0] ADDR_SECOND_LINK = 8'h09;
  localparam logic [7:0] BANK_ONE = 8'h10;
  localparam logic [7:0] ADDR_FIRST_HI = BANK_ONE | ADDR_FIRST_LO;
  localparam logic [7:0] ADDR_SECOND_HI = BANK_ONE | ADDR_SECOND_LO;
  localparam logic [7:0] ADDR_CAPTURE_LO = BANK_ONE | ADDR_THIRD_LO;
  localparam logic [7:0] ADDR_CAPTURE_HI = BANK_ONE | ADDR_THIRD_HI;

  // Byte slots of the shared count and reload storage
  localparam int FIRST_LO = 0;
  localparam int FIRST_HI = 1;
  localparam int SECOND_LO = 2;
  localparam int SECOND_HI = 3;
  localparam int THIRD_LO = 4;
  localparam int THIRD_HI = 5;
  localparam int NUM_BYTES = 6;
  localparam int NUM_TIMERS = 3;

  localparam int WIDE_PRESCALE = 6;
  localparam int NARROW_PRESCALE = 4;
  localparam int PRESCALE_LSB = 2;

  // Cascade field codes
  localparam logic [1:0] CAS_8_8_32 = 2'h0;
  localparam logic [1:0] CAS_16_16_16 = 2'h1;
  localparam logic [1:0] CAS_8_24_16 = 2'h2;
  localparam logic [1:0] CAS_8_16_24 = 2'h3;
  localparam logic [1:0] CASCADE_RESET = CAS_8_8_32;

  // Timer mode register fields
  localparam int TM_LOAD0 = 0;
  localparam int TM_RUN0 = 1;
  localparam int TM_LOAD1 = 2;
  localparam int TM_RUN1 = 3;
  localparam int TM_EXT_LSB = 4;
  localparam int TM_OUT_LSB = 6;
  localparam logic [1:0] OUT_FIRST = 2'h1;
  localparam logic [1:0] OUT_SECOND = 2'h2;

  // Third timer mode register fields
  localparam int M3_LOAD = 0;
  localparam int M3_RUN = 1;
  localparam int M3_CONT = 2;
  localparam int M3_SLOW = 4;
  localparam int M3_INT_EN = 5;
  localparam int M3_OUT_EN = 6;
  localparam int M3_FLAG = 7;

  // Prescale register low bits
  localparam int PS_CONT = 0;
  localparam int PS_EXT_SRC = 1;

  localparam logic [2:0] DIV4_PHASE = 3'h3;
  localparam logic [2:0] DIV8_PHASE = 3'h7;

  typedef enum logic [1:0] {
    EXT_CLOCK = 2'h0,
    EXT_GATE = 2'h1,
    EXT_TRIG_ONCE = 2'h2,
    EXT_TRIG_RETRIG = 2'h3
  } ext_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

/* verilog/cascadable_counter_timers.sv */
// Three cascadable down-counter timers with capture, behind the register file
// Behaviour
// - start, stop, resume and restart commands per counter
// - single pass halts, continuous reloads at zero
// - count reads never disturb; first, second prescalers unreadable
// - second timer clock internal divide-four or pin
// - external input: clock, retrigger, one-shot trigger, gate
// - first timer output can clock second timer
// - first or second timer drives shared output
// - first, second: 6-bit prescaler, 16-bit counter
// - third: 4-bit prescaler, 16-bit counter, capture
// - cascade field sets the three counter lengths
// - extended counters chain bytes high to low
// - third clock crystal/2, or /8 if 16-bit
// - every capture-pin fall latches third count
// - capture register readable, writes ignored
// - third timer output routable to own pin
// - third interrupt ORed with pin edge interrupt
// - end of count sets sticky flag bit 7
// - third count mode examined only at zero
// - power-up 8/8/32, third output and interrupt off
// - third behaves like first otherwise
// - first, second high bytes same offset, other bank
`timescale 1ns/1ps

module prescaler #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic src,
  input wire logic restart,
  input wire logic enable,
  input wire logic [W-1:0] divide,
  output logic tick
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_inc;

  assign cnt_inc = cnt_reg + {{(W-1){1'b0}}, 1'b1};

  // A divide value of zero wraps the full range
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (restart) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (enable && src) begin
      tick <= (cnt_inc == divide);
      cnt_reg <= (cnt_inc == divide) ? '0 : cnt_inc;
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // prescaler

module pin_filter (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Pins idle high, so reset to high avoids a false edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      level <= 1'b1;
      fall <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level <= s2_reg;
      end
      fall <= level & (s2_reg == s3_reg) & ~s2_reg;
    end
  end
endmodule // pin_filter

module cascadable_counter_timers (
  input wire logic clk,
  input wire logic reset_n,
  input timer_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic ext_timer_input_pin,
  input wire logic capture_pin,
  input wire logic shared_irq_pin,
  output logic timer_out_pin,
  output logic third_timer_out_pin,
  output logic interrupt_request_zero
);
  import timer_pkg::*;

  logic [8*NUM_BYTES-1:0] cnt_reg;
  logic [8*NUM_BYTES-1:0] cnt_next;
  logic [8*NUM_BYTES-1:0] rld_reg;
  logic [NUM_TIMERS-1:0] run_reg;
  logic [NUM_TIMERS-1:0] run_next;
  logic [NUM_TIMERS-1:0] tog_reg;
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] load_cmd;
  logic [NUM_TIMERS-1:0] cont;
  logic [NUM_TIMERS-1:0] eoc;
  logic [NUM_TIMERS-1:0] src;
  logic [31:0] cur [NUM_TIMERS];
  logic [31:0] rld [NUM_TIMERS];
  logic [31:0] nxt [NUM_TIMERS];
  logic [7:0] first_ps_reg;
  logic [7:0] second_ps_reg;
  logic [7:0] cascade_reg;
  logic [1:0] ext_mode_reg;
  logic [1:0] out_sel_reg;
  logic [7:0] third_mode_reg;
  logic second_link_reg;
  logic [15:0] capture_reg;
  logic [2:0] div_reg;
  logic div2;
  logic div4;
  logic div8;
  logic ext_level;
  logic ext_fall;
  logic cap_fall;
  logic irq_fall;
  logic trig;
  logic slow_ok;
  logic [1:0] cas;

  function automatic logic [95:0] pack(input logic [1:0] c,
                                       input logic [47:0] v);
    logic [7:0] b [NUM_BYTES];
    for (int i = 0; i < NUM_BYTES; i++) begin
      b[i] = v[8*i +: 8];
    end
    case (c)
      CAS_8_8_32: pack = {24'h00_0000, b[FIRST_LO], 24'h00_0000, b[SECOND_LO],
                          b[FIRST_HI], b[SECOND_HI], b[THIRD_HI], b[THIRD_LO]};
      CAS_16_16_16: pack = {16'h0000, b[FIRST_HI], b[FIRST_LO],
                            16'h0000, b[SECOND_HI], b[SECOND_LO],
                            16'h0000, b[THIRD_HI], b[THIRD_LO]};
      CAS_8_24_16: pack = {24'h00_0000, b[FIRST_LO],
                           8'h00, b[FIRST_HI], b[SECOND_HI], b[SECOND_LO],
                           16'h0000, b[THIRD_HI], b[THIRD_LO]};
      default: pack = {24'h00_0000, b[FIRST_LO],
                       16'h0000, b[SECOND_HI], b[SECOND_LO],
                       8'h00, b[FIRST_HI], b[THIRD_HI], b[THIRD_LO]};
    endcase
  endfunction

  function automatic logic [47:0] unpack(input logic [1:0] c,
                                         input logic [31:0] a,
                                         input logic [31:0] s,
                                         input logic [31:0] t);
    logic [7:0] b [NUM_BYTES];
    b[FIRST_LO] = a[7:0];
    b[THIRD_LO] = t[7:0];
    b[THIRD_HI] = t[15:8];
    case (c)
      CAS_8_8_32: begin
        b[SECOND_LO] = s[7:0];
        b[SECOND_HI] = t[23:16];
        b[FIRST_HI] = t[31:24];
      end
      CAS_16_16_16: begin
        b[FIRST_HI] = a[15:8];
        b[SECOND_LO] = s[7:0];
        b[SECOND_HI] = s[15:8];
      end
      CAS_8_24_16: begin
        b[SECOND_LO] = s[7:0];
        b[SECOND_HI] = s[15:8];
        b[FIRST_HI] = s[23:16];
      end
      default: begin
        b[SECOND_LO] = s[7:0];
        b[SECOND_HI] = s[15:8];
        b[FIRST_HI] = t[23:16];
      end
    endcase
    unpack = {b[5], b[4], b[3], b[2], b[1], b[0]};
  endfunction

  wire logic wr_en = reg_req.wr;
  wire logic [7:0] wa = reg_req.addr;
  wire logic [7:0] wd = reg_req.wdata;

  assign cas = cascade_reg[1:0];
  // Slow third clock only when the third counter is 16 bits long
  assign slow_ok = (cas == CAS_16_16_16) || (cas == CAS_8_24_16);
  assign div2 = div_reg[0];
  assign div4 = (div_reg[1:0] == DIV4_PHASE[1:0]);
  assign div8 = (div_reg == DIV8_PHASE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  pin_filter ext_filter (
    .clk(clk), .reset_n(reset_n), .pin(ext_timer_input_pin),
    .level(ext_level), .fall(ext_fall));
  pin_filter cap_filter (
    .clk(clk), .reset_n(reset_n), .pin(capture_pin),
    .level(), .fall(cap_fall));
  pin_filter irq_filter (
    .clk(clk), .reset_n(reset_n), .pin(shared_irq_pin),
    .level(), .fall(irq_fall));

  // Trigger modes only apply with the internal source selected
  assign trig = ~second_ps_reg[PS_EXT_SRC] & ~second_link_reg & ext_fall &
    ((ext_mode_reg == EXT_TRIG_RETRIG) ||
     ((ext_mode_reg == EXT_TRIG_ONCE) && ~run_reg[1]));

  always_comb begin
    src[0] = div4;
    if (second_link_reg) begin
      src[1] = eoc[0];
    end else if (second_ps_reg[PS_EXT_SRC]) begin
      src[1] = ext_fall;
    end else if (ext_mode_reg == EXT_GATE) begin
      src[1] = div4 & ext_level;
    end else begin
      src[1] = div4;
    end
    src[2] = (third_mode_reg[M3_SLOW] && slow_ok) ? div8 : div2;
  end

  assign load_cmd[0] = wr_en && (wa == ADDR_TIMER_MODE) && wd[TM_LOAD0];
  assign load_cmd[1] = (wr_en && (wa == ADDR_TIMER_MODE) && wd[TM_LOAD1]) |
    trig;
  assign load_cmd[2] = wr_en && (wa == ADDR_THIRD_MODE) && wd[M3_LOAD];
  assign cont[0] = first_ps_reg[PS_CONT];
  assign cont[1] = second_ps_reg[PS_CONT];
  assign cont[2] = third_mode_reg[M3_CONT];

  prescaler #(.W(WIDE_PRESCALE)) first_pre (
    .clk(clk), .reset_n(reset_n), .src(src[0]), .restart(load_cmd[0]),
    .enable(run_reg[0]), .divide(first_ps_reg[7:PRESCALE_LSB]),
    .tick(tick[0]));
  prescaler #(.W(WIDE_PRESCALE)) second_pre (
    .clk(clk), .reset_n(reset_n), .src(src[1]), .restart(load_cmd[1]),
    .enable(run_reg[1]), .divide(second_ps_reg[7:PRESCALE_LSB]),
    .tick(tick[1]));
  prescaler #(.W(NARROW_PRESCALE)) third_pre (
    .clk(clk), .reset_n(reset_n), .src(src[2]), .restart(load_cmd[2]),
    .enable(run_reg[2]),
    .divide(cascade_reg[PRESCALE_LSB +: NARROW_PRESCALE]),
    .tick(tick[2]));

  // Counters of any length are assembled from the six bytes
  always_comb begin
    {cur[0], cur[1], cur[2]} = pack(cas, cnt_reg);
    {rld[0], rld[1], rld[2]} = pack(cas, rld_reg);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      eoc[i] = tick[i] & run_reg[i] & ~load_cmd[i] & (cur[i] <= 32'h0000_0001);
      if (load_cmd[i]) begin
        nxt[i] = rld[i];
      end else if (eoc[i]) begin
        // Mode bit is sampled here only, at the zero crossing
        nxt[i] = cont[i] ? rld[i] : 32'h0000_0000;
      end else if (tick[i] && run_reg[i]) begin
        nxt[i] = cur[i] - 32'h0000_0001;
      end else begin
        nxt[i] = cur[i];
      end
    end
    cnt_next = unpack(cas, nxt[0], nxt[1], nxt[2]);
  end

  always_comb begin
    run_next = run_reg;
    if (wr_en && (wa == ADDR_TIMER_MODE)) begin
      run_next[0] = wd[TM_RUN0];
      run_next[1] = wd[TM_RUN1];
    end
    if (wr_en && (wa == ADDR_THIRD_MODE)) begin
      run_next[2] = wd[M3_RUN];
    end
    if (trig) begin
      run_next[1] = 1'b1;
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (eoc[i] && !cont[i]) begin
        run_next[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      run_reg <= '0;
      tog_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      tog_reg <= tog_reg ^ eoc;
    end
  end

  // Writes to a count address program the reload byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rld_reg <= '0;
    end else if (wr_en) begin
      case (wa)
        ADDR_FIRST_LO: rld_reg[8*FIRST_LO +: 8] <= wd;
        ADDR_FIRST_HI: rld_reg[8*FIRST_HI +: 8] <= wd;
        ADDR_SECOND_LO: rld_reg[8*SECOND_LO +: 8] <= wd;
        ADDR_SECOND_HI: rld_reg[8*SECOND_HI +: 8] <= wd;
        ADDR_THIRD_LO: rld_reg[8*THIRD_LO +: 8] <= wd;
        ADDR_THIRD_HI: rld_reg[8*THIRD_HI +: 8] <= wd;
        default: rld_reg <= rld_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_ps_reg <= 8'h00;
      second_ps_reg <= 8'h00;
      cascade_reg <= {6'h00, CASCADE_RESET};
      ext_mode_reg <= EXT_CLOCK;
      out_sel_reg <= 2'h0;
      second_link_reg <= 1'b0;
    end else if (wr_en) begin
      case (wa)
        ADDR_FIRST_PRESCALE: first_ps_reg <= wd;
        ADDR_SECOND_PRESCALE: second_ps_reg <= wd;
        ADDR_PRESCALE_CASCADE: cascade_reg <= wd;
        ADDR_TIMER_MODE: begin
          ext_mode_reg <= wd[TM_EXT_LSB +: 2];
          out_sel_reg <= wd[TM_OUT_LSB +: 2];
        end
        ADDR_SECOND_LINK: second_link_reg <= wd[0];
        default: second_link_reg <= second_link_reg;
      endcase
    end
  end

  // Flag: software writes zero to clear, end of count wins a tie
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      third_mode_reg <= 8'h00;
    end else begin
      if (wr_en && (wa == ADDR_THIRD_MODE)) begin
        third_mode_reg[6:0] <= {wd[6:2], 2'h0};
        third_mode_reg[M3_FLAG] <= eoc[2] |
          (third_mode_reg[M3_FLAG] & wd[M3_FLAG]);
      end else if (eoc[2]) begin
        third_mode_reg[M3_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_reg <= 16'h0000;
    end else if (cap_fall) begin
      capture_reg <= cnt_reg[8*THIRD_LO +: 16];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_out_pin <= 1'b0;
      third_timer_out_pin <= 1'b0;
      interrupt_request_zero <= 1'b0;
    end else begin
      timer_out_pin <= (out_sel_reg == OUT_FIRST) ? tog_reg[0] :
                       (out_sel_reg == OUT_SECOND) ? tog_reg[1] :
                       1'b0;
      third_timer_out_pin <= third_mode_reg[M3_OUT_EN] & tog_reg[2];
      interrupt_request_zero <= (eoc[2] & third_mode_reg[M3_INT_EN]) |
        irq_fall;
    end
  end

  // Reads have no side effect; first and second prescale values are write-only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_FIRST_LO: reg_rdata <= cnt_reg[8*FIRST_LO +: 8];
        ADDR_FIRST_HI: reg_rdata <= cnt_reg[8*FIRST_HI +: 8];
        ADDR_SECOND_LO: reg_rdata <= cnt_reg[8*SECOND_LO +: 8];
        ADDR_SECOND_HI: reg_rdata <= cnt_reg[8*SECOND_HI +: 8];
        ADDR_THIRD_LO: reg_rdata <= cnt_reg[8*THIRD_LO +: 8];
        ADDR_THIRD_HI: reg_rdata <= cnt_reg[8*THIRD_HI +: 8];
        ADDR_CAPTURE_LO: reg_rdata <= capture_reg[7:0];
        ADDR_CAPTURE_HI: reg_rdata <= capture_reg[15:8];
        ADDR_PRESCALE_CASCADE: reg_rdata <= cascade_reg;
        ADDR_TIMER_MODE: reg_rdata <= {out_sel_reg, ext_mode_reg,
                                       run_reg[1], 1'b0, run_reg[0], 1'b0};
        ADDR_THIRD_MODE: reg_rdata <= {third_mode_reg[7:2], run_reg[2], 1'b0};
        ADDR_SECOND_LINK: reg_rdata <= {7'h00, second_link_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // cascadable_counter_timers

/* verification/cascadable_counter_timers_sva.sv */
// Assertion checker for the cascadable timers, bound to the top module
`timescale 1ns/1ps
module cascadable_counter_timers_chk (
  input wire logic clk,
  input wire logic reset_n,
  input timer_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_timer_input_pin,
  input wire logic capture_pin,
  input wire logic shared_irq_pin,
  input wire logic timer_out_pin,
  input wire logic third_timer_out_pin,
  input wire logic interrupt_request_zero
);
  import timer_pkg::*;
  logic out_en_reg, int_en_reg, flag_seen_reg, rd_mode_reg, pin_prev_reg;
  logic [3:0] pin_age_reg;
  logic mode_wr;
  assign mode_wr = reg_req.wr && reg_req.addr == ADDR_THIRD_MODE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_en_reg <= 1'b0;
      int_en_reg <= 1'b0;
    end else if (mode_wr) begin
      out_en_reg <= reg_req.wdata[M3_OUT_EN];
      int_en_reg <= reg_req.wdata[M3_INT_EN];
    end
  end

  // The flag is only known to be set once software has read it set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_mode_reg <= 1'b0;
      flag_seen_reg <= 1'b0;
    end else begin
      rd_mode_reg <= reg_req.rd && reg_req.addr == ADDR_THIRD_MODE;
      if (mode_wr && !reg_req.wdata[M3_FLAG]) flag_seen_reg <= 1'b0;
      else if (rd_mode_reg && reg_rdata[M3_FLAG]) flag_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev_reg <= 1'b1;
      pin_age_reg <= 4'hF;
    end else begin
      pin_prev_reg <= shared_irq_pin;
      if (pin_prev_reg && !shared_irq_pin) pin_age_reg <= 4'h0;
      else if (pin_age_reg != 4'hF) pin_age_reg <= pin_age_reg + 4'h1;
    end
  end

  a_irq_one_pulse: assert property (
    interrupt_request_zero |=> !interrupt_request_zero)
    else $error("interrupt request held longer than one cycle");
  a_irq_has_cause: assert property (
    interrupt_request_zero |-> int_en_reg || $past(int_en_reg)
      || pin_age_reg <= 4'hA)
    else $error("interrupt request without enabled source");
  a_quiet_after_reset: assert property (
    $rose(reset_n) |-> !timer_out_pin && !third_timer_out_pin
      && !interrupt_request_zero && reg_rdata == 8'h00)
    else $error("outputs not idle after reset");
  a_third_out_gated: assert property (
    !out_en_reg && !$past(out_en_reg) |-> !third_timer_out_pin)
    else $error("third timer pin driven while disabled");
  a_prescale_unread: assert property (
    reg_req.rd && (reg_req.addr == ADDR_FIRST_PRESCALE
      || reg_req.addr == ADDR_SECOND_PRESCALE) |=> reg_rdata == 8'h00)
    else $error("prescaler value readable");
  a_flag_sticky: assert property (
    rd_mode_reg && flag_seen_reg |-> reg_rdata[M3_FLAG])
    else $error("end flag cleared without software");
  a_out_min_gap: assert property (
    $changed(timer_out_pin) |=> $stable(timer_out_pin) [*3])
    else $error("timer output toggles faster than its prescaler");
  a_unmapped_zero: assert property (
    reg_req.rd && reg_req.addr > ADDR_CAPTURE_HI |=> reg_rdata == 8'h00)
    else $error("unmapped address returned data");

  c_irq: cover property (interrupt_request_zero);
  c_out_toggle: cover property ($changed(timer_out_pin));
  c_flag_read: cover property (rd_mode_reg && flag_seen_reg);
endmodule // cascadable_counter_timers_chk

bind cascadable_counter_timers cascadable_counter_timers_chk
  cascadable_counter_timers_chk_inst (
  .clk(clk),
  .reset_n(reset_n),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .ext_timer_input_pin(ext_timer_input_pin),
  .capture_pin(capture_pin),
  .shared_irq_pin(shared_irq_pin),
  .timer_out_pin(timer_out_pin),
  .third_timer_out_pin(third_timer_out_pin),
  .interrupt_request_zero(interrupt_request_zero)
);

/* verification/port_pins.sv */
// Model of the port input pins that face the timer block
`timescale 1ns/1ps
module port_pins (
  input wire logic clk,
  output logic ext_timer_input_pin,
  output logic capture_pin,
  output logic shared_irq_pin
);
  // Idle pins rest at the pull-up level
  initial begin
    ext_timer_input_pin = 1'b1;
    capture_pin = 1'b1;
    shared_irq_pin = 1'b1;
  end
  // Held low long enough for the three-flop filter to accept the edge
  task automatic fall(input int which);
    @(negedge clk);
    if (which == 1) capture_pin = 1'b0;
    else if (which == 3) ext_timer_input_pin = 1'b0;
    else shared_irq_pin = 1'b0;
    repeat (8) @(negedge clk);
    capture_pin = 1'b1;
    shared_irq_pin = 1'b1;
    ext_timer_input_pin = 1'b1;
  endtask
endmodule // port_pins

/* verification/tb.sv */
// Self-checking testbench for the cascadable timers
`timescale 1ns/1ps
module tb;
  import timer_pkg::*;
  logic clk, reset_n, etp, cap, sip, top, ttop, irq;
  reg_req_t reg_req;
  logic [7:0] reg_rdata, v, x;
  int bad_count, n_tests, cnt, cnt2;

  cascadable_counter_timers cascadable_counter_timers_inst (.clk(clk),
    .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .ext_timer_input_pin(etp), .capture_pin(cap), .shared_irq_pin(sip),
    .timer_out_pin(top), .third_timer_out_pin(ttop),
    .interrupt_request_zero(irq));
  port_pins port_pins_inst (.clk(clk), .ext_timer_input_pin(etp),
    .capture_pin(cap), .shared_irq_pin(sip));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    reg_req.rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic count_irq(input int n);
    logic p;
    cnt = 0;
    cnt2 = 0;
    p = ttop;
    repeat (n) begin
      @(negedge clk);
      if (irq === 1'b1) cnt++;
      if (ttop !== p) cnt2++;
      p = ttop;
    end
  endtask
  task automatic gap(output int n);
    logic p;
    p = top;
    n = 0;
    while (top === p && n < 100) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic tdone(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(100 * 4000);
    bad_count++;
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0;
    reg_req = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    rdc(ADDR_PRESCALE_CASCADE, 8'h00);
    rdc(ADDR_THIRD_MODE, 8'h00);
    rdc(ADDR_TIMER_MODE, 8'h00);
    wr(ADDR_FIRST_PRESCALE, 8'hFD);
    rdc(ADDR_FIRST_PRESCALE, 8'h00);
    rdc(8'h20, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PRESCALE_CASCADE, {6'h01, 2'(i)});
      rdc(ADDR_PRESCALE_CASCADE, {6'h01, 2'(i)});
    end
    tdone("reset");
    // First timer stays 8-bit so a serial bit clock would keep working
    wr(ADDR_PRESCALE_CASCADE, {6'h01, CAS_8_8_32});
    wr(ADDR_FIRST_LO, 8'h04);
    wr(ADDR_FIRST_PRESCALE, 8'h05);
    wr(ADDR_TIMER_MODE, 8'h43);
    gap(cnt);
    gap(cnt);
    chk("first period", 8'h10, 8'(cnt));
    repeat (6) @(negedge clk);
    wr(ADDR_TIMER_MODE, 8'h00);
    repeat (2) @(negedge clk);
    chk("out off", 8'h00, {7'h00, top});
    tdone("first");
    wr(ADDR_PRESCALE_CASCADE, {6'h01, CAS_8_24_16});
    wr(ADDR_FIRST_HI, 8'h01);
    wr(ADDR_SECOND_HI, 8'h00);
    wr(ADDR_SECOND_LO, 8'h00);
    wr(ADDR_SECOND_PRESCALE, 8'h04);
    wr(ADDR_TIMER_MODE, 8'h0C);
    repeat (10) @(negedge clk);
    wr(ADDR_TIMER_MODE, 8'h00);
    rdc(ADDR_FIRST_HI, 8'h00);
    rdc(ADDR_SECOND_HI, 8'hFF);
    rd(ADDR_SECOND_LO, x);
    wr(ADDR_TIMER_MODE, 8'h08);
    repeat (10) @(negedge clk);
    wr(ADDR_TIMER_MODE, 8'h00);
    rd(ADDR_SECOND_LO, v);
    chk("resume", 8'h01, {7'h00, v < x});
    tdone("second 24-bit");
    wr(ADDR_PRESCALE_CASCADE, {6'h01, CAS_16_16_16});
    wr(ADDR_THIRD_LO, 8'h03);
    wr(ADDR_THIRD_HI, 8'h00);
    wr(ADDR_THIRD_MODE, 8'h67);
    count_irq(60);
    chk("irq count", 8'h01, {7'h00, cnt >= 9 && cnt <= 11});
    chk("pin toggles", 8'h01, {7'h00, cnt2 >= 9 && cnt2 <= 11});
    wr(ADDR_THIRD_MODE, 8'h62);
    repeat (20) @(negedge clk);
    for (int i = 0; i < 2; i++) begin
      rd(ADDR_THIRD_MODE, v);
      chk("end flag", 8'h01, {7'h00, v[M3_FLAG]});
    end
    rdc(ADDR_THIRD_LO, 8'h00);
    repeat (10) @(negedge clk);
    rdc(ADDR_THIRD_LO, 8'h00);
    wr(ADDR_THIRD_MODE, 8'h00);
    rd(ADDR_THIRD_MODE, v);
    chk("flag cleared", 8'h00, {7'h00, v[M3_FLAG]});
    tdone("third modes");
    // Slow clock: one tick per eight cycles, so one toggle per 24 cycles
    wr(ADDR_THIRD_MODE, 8'h57);
    count_irq(120);
    chk("slow toggles", 8'h01, {7'h00, cnt2 >= 4 && cnt2 <= 7});
    wr(ADDR_THIRD_MODE, 8'h00);
    tdone("slow third");
    wr(ADDR_FIRST_LO, 8'h02);
    wr(ADDR_FIRST_HI, 8'h00);
    wr(ADDR_SECOND_LO, 8'h02);
    wr(ADDR_SECOND_PRESCALE, 8'h05);
    wr(ADDR_SECOND_LINK, 8'h01);
    wr(ADDR_TIMER_MODE, 8'h8F);
    gap(cnt);
    gap(cnt);
    chk("linked period", 8'h10, 8'(cnt));
    // Stop but keep the output selection so the pin does not jump
    wr(ADDR_TIMER_MODE, 8'h80);
    wr(ADDR_SECOND_LINK, 8'h00);
    wr(ADDR_SECOND_PRESCALE, 8'h06);
    wr(ADDR_TIMER_MODE, 8'h0C);
    port_pins_inst.fall(3);
    rdc(ADDR_SECOND_LO, 8'h01);
    // Stop before leaving the pin source, so no internal tick slips in
    wr(ADDR_TIMER_MODE, 8'h20);
    wr(ADDR_SECOND_PRESCALE, 8'h04);
    port_pins_inst.fall(3);
    repeat (10) @(negedge clk);
    rdc(ADDR_SECOND_LO, 8'h00);
    wr(ADDR_TIMER_MODE, 8'h00);
    tdone("link and external input");
    wr(ADDR_PRESCALE_CASCADE, {6'h01, CAS_8_8_32});
    wr(ADDR_FIRST_HI, 8'h01);
    wr(ADDR_SECOND_HI, 8'h00);
    wr(ADDR_THIRD_HI, 8'h00);
    wr(ADDR_THIRD_LO, 8'h00);
    wr(ADDR_THIRD_MODE, 8'h03);
    repeat (4) @(negedge clk);
    wr(ADDR_THIRD_MODE, 8'h00);
    rdc(ADDR_FIRST_HI, 8'h00);
    rdc(ADDR_SECOND_HI, 8'hFF);
    rdc(ADDR_THIRD_HI, 8'hFF);
    rd(ADDR_THIRD_LO, x);
    port_pins_inst.fall(1);
    repeat (10) @(negedge clk);
    rdc(ADDR_CAPTURE_LO, x);
    rdc(ADDR_CAPTURE_HI, 8'hFF);
    wr(ADDR_CAPTURE_LO, ~x);
    rdc(ADDR_CAPTURE_LO, x);
    rdc(ADDR_THIRD_LO, x);
    tdone("chain and capture");
    fork
      port_pins_inst.fall(2);
      count_irq(20);
    join
    chk("pin irq", 8'h01, 8'(cnt));
    tdone("shared irq");
    report_and_stop();
  end
endmodule // tb
